// *** rtl/pmi_map.svh ***
// Register offsets, field positions, reset values and memory map constants
`ifndef PMI_MAP_SVH
`define PMI_MAP_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define PMI_OFF_CTRL 5'h0_0
`define PMI_OFF_EXTB 5'h0_4
`define PMI_OFF_MODE 5'h0_8
`define PMI_OFF_STAT 5'h0_c
// ****************************************
// Control fields and reset values
// ****************************************
`define PMI_CTRL_WS_LSB 0
`define PMI_CTRL_WS_MSB 2
`define PMI_CTRL_CKODIS 14
`define PMI_CTRL_GIE 15
`define PMI_WS_RST 3'h7
`define PMI_MODE_RST 7'h0_0
`define PMI_EXTB_RST 8'h0_0
// ****************************************
// Program memory map
// ****************************************
`define PMI_LOW_TOP 14'h0_800
`define PMI_HIGH_BASE 14'h3_800
`define PMI_START_PC 14'h0_000
`define PMI_RESP_OK 2'h0
`define PMI_RESP_DEC 2'h3
`endif

// *** rtl/pmi_pkg.sv ***
// Types shared by the program memory interface files
package pmi_pkg;
    typedef logic [13:0] pmi_addr_t;
    typedef logic [23:0] pmi_word_t;
    typedef logic [15:0] pmi_data_t;
    typedef enum logic [1:0] {PMI_IDLE, PMI_INT, PMI_EXT} pmi_acc_t;
    typedef enum logic [1:0] {PMI_DECIDE, PMI_BOOT, PMI_RUN} pmi_boot_t;
endpackage

// *** rtl/pmi_ram.sv ***
// Internal program RAM with registered read data
`timescale 1ns/100ps
module pmi_ram #(
    parameter int AW = 11,
    parameter int DW = 24
) (
    input wire logic clk_in,
    input wire logic we_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [DW-1:0] wdata_in,
    output logic [DW-1:0] rdata_out
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
        rdata_out <= mem[addr_in];
    end
endmodule

// *** rtl/pmi_top.sv ***
// Program memory interface with start-up control and register slave
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "pmi_map.svh"

module pmi_top #(
    parameter int INSN_DIV = 1,
    parameter int RAM_AW = 11
) (
    input wire logic clk_in,
    input wire logic rst_in,
    // AXI4-Lite slave
    input wire logic [4:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [4:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Straps and start-up
    input wire logic memory_map_select_in,
    input wire logic bus_request_in,
    input wire logic boot_done_in,
    output logic boot_start_out,
    output logic run_start_out,
    output pmi_pkg::pmi_addr_t start_pc_out,
    output logic stack_reset_out,
    output logic irq_mask_all_out,
    output logic ints_enabled_out,
    output logic instruction_clock_output,
    // Core side program memory requests
    input wire logic pm_req_in,
    input wire logic pm_we_in,
    input wire logic pm_data_in,
    input wire pmi_pkg::pmi_addr_t pm_addr_in,
    input wire pmi_pkg::pmi_data_t pm_wdata_in,
    output logic pm_ack_out,
    output pmi_pkg::pmi_word_t pm_rdata_out,
    // External bus
    output pmi_pkg::pmi_addr_t program_address_bus_out,
    output logic program_address_bus_oe_n_out,
    output pmi_pkg::pmi_word_t program_data_bus_out,
    output logic program_data_bus_oe_n_out,
    input wire pmi_pkg::pmi_word_t program_data_bus_in,
    output logic program_memory_select_n_out,
    output logic rd_n_out,
    output logic wr_n_out
);
    import pmi_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [2:0] ws_r;
    logic clock_output_disable_r;
    logic gie_r;
    logic [7:0] program_memory_extension_reg;
    logic [6:0] mode_status_register;
    logic map_r;
    pmi_boot_t boot_r;
    pmi_acc_t acc_r;
    logic [2:0] cnt_r;
    logic we_q;
    logic data_q;
    logic [15:0] div_r;
    logic aw_hold_r;
    logic w_hold_r;
    logic [4:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    // ****************************************
    // Decode
    // ****************************************
    wire running = (boot_r == PMI_RUN);
    wire take = running && (acc_r == PMI_IDLE) && pm_req_in && !pm_ack_out;
    wire in_low = (pm_addr_in < `PMI_LOW_TOP);
    wire in_high = (pm_addr_in >= `PMI_HIGH_BASE);
    wire ext_hit = map_r ? !in_high : !in_low;
    wire [RAM_AW-1:0] ram_addr = pm_addr_in[RAM_AW-1:0];
    wire ram_we = take && !ext_hit && pm_we_in;
    wire [23:0] wr_word = {pm_wdata_in, program_memory_extension_reg};
    wire [23:0] ram_rdata;
    wire ext_last = (acc_r == PMI_EXT) && (cnt_r == 3'h0);
    wire xb_load_int = (acc_r == PMI_INT) && data_q && !we_q;
    wire xb_load_ext = ext_last && data_q && !we_q;
    wire div_end = (div_r == 16'(INSN_DIV - 1));
    wire aw_have = aw_hold_r || s_axi_awvalid_in;
    wire w_have = w_hold_r || s_axi_wvalid_in;
    wire do_wr = aw_have && w_have && !s_axi_bvalid_out;
    wire [4:0] wa = aw_hold_r ? awaddr_r : s_axi_awaddr_in;
    wire [31:0] wd = w_hold_r ? wdata_r : s_axi_wdata_in;
    wire [3:0] ws = w_hold_r ? wstrb_r : s_axi_wstrb_in;
    wire wr_ctrl = do_wr && (wa == `PMI_OFF_CTRL);
    wire wr_xb = do_wr && (wa == `PMI_OFF_EXTB) && ws[0];
    wire wr_ms = do_wr && (wa == `PMI_OFF_MODE) && ws[0];
    wire wr_ok = (wa == `PMI_OFF_CTRL) || (wa == `PMI_OFF_EXTB) ||
        (wa == `PMI_OFF_MODE) || (wa == `PMI_OFF_STAT);
    wire rd_go = s_axi_arvalid_in && s_axi_arready_out;
    wire [31:0] ctrl_word = {16'h0_000, gie_r, clock_output_disable_r, 11'h0_00, ws_r};
    wire [31:0] stat_word = {28'h000_0000, gie_r, running,
        (boot_r == PMI_BOOT), map_r};
    wire rd_ok = (s_axi_araddr_in == `PMI_OFF_CTRL) ||
        (s_axi_araddr_in == `PMI_OFF_EXTB) ||
        (s_axi_araddr_in == `PMI_OFF_MODE) ||
        (s_axi_araddr_in == `PMI_OFF_STAT);
    wire [31:0] rd_word =
        (s_axi_araddr_in == `PMI_OFF_CTRL) ? ctrl_word :
        (s_axi_araddr_in == `PMI_OFF_EXTB) ?
            {24'h00_0000, program_memory_extension_reg} :
        (s_axi_araddr_in == `PMI_OFF_MODE) ?
            {25'h000_0000, mode_status_register} :
        (s_axi_araddr_in == `PMI_OFF_STAT) ? stat_word : 32'h0000_0000;

    pmi_ram #(.AW(RAM_AW), .DW(24)) u_ram (
        .clk_in(clk_in),
        .we_in(ram_we),
        .addr_in(ram_addr),
        .wdata_in(wr_word),
        .rdata_out(ram_rdata)
    );

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 5'h0_0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `PMI_RESP_OK;
        end else begin
            s_axi_awready_out <= !aw_hold_r && !s_axi_bvalid_out;
            s_axi_wready_out <= !w_hold_r && !s_axi_bvalid_out;
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata_in;
                wstrb_r <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'b0;
            end
            if (aw_hold_r && w_hold_r && !s_axi_bvalid_out) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= wr_ok ? `PMI_RESP_OK : `PMI_RESP_DEC;
            end
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= `PMI_RESP_OK;
        end else begin
            s_axi_arready_out <= !s_axi_rvalid_out && !rd_go;
            if (rd_go) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= rd_word;
                s_axi_rresp_out <= rd_ok ? `PMI_RESP_OK : `PMI_RESP_DEC;
            end else if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    // ****************************************
    // Software registers
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ws_r <= `PMI_WS_RST;
            clock_output_disable_r <= 1'b0;
            gie_r <= 1'b1;
            mode_status_register <= `PMI_MODE_RST;
        end else begin
            if (wr_ctrl && ws[0]) begin
                ws_r <= wd[`PMI_CTRL_WS_MSB:`PMI_CTRL_WS_LSB];
            end
            if (wr_ctrl && ws[1]) begin
                clock_output_disable_r <= wd[`PMI_CTRL_CKODIS];
                gie_r <= wd[`PMI_CTRL_GIE];
            end
            if (wr_ms) begin
                mode_status_register <= wd[6:0];
            end
        end
    end

    // Core loads of the extension byte win over a software write
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            program_memory_extension_reg <= `PMI_EXTB_RST;
        end else if (xb_load_ext) begin
            program_memory_extension_reg <= program_data_bus_in[7:0];
        end else if (xb_load_int) begin
            program_memory_extension_reg <= ram_rdata[7:0];
        end else if (wr_xb) begin
            program_memory_extension_reg <= wd[7:0];
        end
    end

    // ****************************************
    // Start-up sequence
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            map_r <= memory_map_select_in;
            boot_r <= PMI_DECIDE;
            boot_start_out <= 1'b0;
            run_start_out <= 1'b0;
            start_pc_out <= `PMI_START_PC;
            stack_reset_out <= 1'b1;
            irq_mask_all_out <= 1'b1;
            ints_enabled_out <= 1'b1;
        end else begin
            boot_start_out <= 1'b0;
            run_start_out <= 1'b0;
            stack_reset_out <= 1'b0;
            ints_enabled_out <= gie_r;
            case (boot_r)
                PMI_DECIDE: begin
                    if (map_r) begin
                        boot_r <= PMI_RUN;
                        run_start_out <= 1'b1;
                        irq_mask_all_out <= 1'b0;
                    end else if (!bus_request_in) begin
                        boot_r <= PMI_BOOT;
                        boot_start_out <= 1'b1;
                    end
                end
                PMI_BOOT: begin
                    if (boot_done_in) begin
                        boot_r <= PMI_RUN;
                        run_start_out <= 1'b1;
                        irq_mask_all_out <= 1'b0;
                    end
                end
                PMI_RUN: begin
                    boot_r <= PMI_RUN;
                end
                default: begin
                    boot_r <= PMI_DECIDE;
                end
            endcase
        end
    end

    // ****************************************
    // Instruction clock output
    // ****************************************
    // Divider restarts with reset; the core clock itself never stops
    always_ff @(posedge clk_in) begin
        if (rst_in || div_end) begin
            div_r <= 16'h0_000;
        end else begin
            div_r <= div_r + 16'h0_001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || clock_output_disable_r) begin
            instruction_clock_output <= 1'b0;
        end else if (div_end) begin
            instruction_clock_output <= !instruction_clock_output;
        end
    end

    // ****************************************
    // Program memory access sequencer
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            acc_r <= PMI_IDLE;
            cnt_r <= 3'h0;
            we_q <= 1'b0;
            data_q <= 1'b0;
            pm_ack_out <= 1'b0;
            pm_rdata_out <= 24'h00_0000;
            program_address_bus_out <= 14'h0_000;
            program_address_bus_oe_n_out <= 1'b1;
            program_data_bus_out <= 24'h00_0000;
            program_data_bus_oe_n_out <= 1'b1;
            program_memory_select_n_out <= 1'b1;
            rd_n_out <= 1'b1;
            wr_n_out <= 1'b1;
        end else begin
            pm_ack_out <= 1'b0;
            case (acc_r)
                PMI_IDLE: begin
                    if (take) begin
                        we_q <= pm_we_in;
                        data_q <= pm_data_in;
                        acc_r <= ext_hit ? PMI_EXT : PMI_INT;
                        cnt_r <= ws_r;
                        if (ext_hit) begin
                            program_address_bus_out <= pm_addr_in;
                            program_address_bus_oe_n_out <= 1'b0;
                            program_data_bus_out <= wr_word;
                            program_data_bus_oe_n_out <= !pm_we_in;
                            program_memory_select_n_out <= 1'b0;
                            rd_n_out <= pm_we_in;
                            wr_n_out <= !pm_we_in;
                        end
                    end
                end
                PMI_INT: begin
                    acc_r <= PMI_IDLE;
                    pm_ack_out <= 1'b1;
                    pm_rdata_out <= ram_rdata;
                end
                PMI_EXT: begin
                    if (cnt_r == 3'h0) begin
                        acc_r <= PMI_IDLE;
                        pm_ack_out <= 1'b1;
                        pm_rdata_out <= program_data_bus_in;
                        program_address_bus_oe_n_out <= 1'b1;
                        program_data_bus_oe_n_out <= 1'b1;
                        program_memory_select_n_out <= 1'b1;
                        rd_n_out <= 1'b1;
                        wr_n_out <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r - 3'h1;
                    end
                end
                default: begin
                    acc_r <= PMI_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_wait_length: assert property (
        $fell(program_memory_select_n_out) && cnt_r == 3'h7 |->
        !program_memory_select_n_out [*8] ##1 program_memory_select_n_out)
        else $error("external access length wrong for seven waits");
    chk_strobe_idle: assert property (
        acc_r != PMI_EXT |->
        program_memory_select_n_out && rd_n_out && wr_n_out)
        else $error("strobe active without external access");
    chk_bus_release: assert property (
        program_memory_select_n_out |->
        program_data_bus_oe_n_out && program_address_bus_oe_n_out)
        else $error("bus driven while no external access");
    chk_strobe_qual: assert property (
        !rd_n_out || !wr_n_out |->
        !program_memory_select_n_out && (rd_n_out != wr_n_out))
        else $error("strobe not qualified by select");
    chk_xb_write: assert property (
        take && ext_hit && pm_we_in |=>
        program_data_bus_out[7:0] == $past(program_memory_extension_reg))
        else $error("extension byte missing from write");
    chk_xb_load: assert property (
        xb_load_ext |=>
        program_memory_extension_reg == $past(program_data_bus_in[7:0]))
        else $error("extension byte not loaded on data read");
    chk_map_decode: assert property (
        take |=> (acc_r == PMI_EXT) ==
        ($past(map_r) ? !$past(in_high) : !$past(in_low)))
        else $error("program memory map decode wrong");
    chk_boot_first: assert property (
        run_start_out && !map_r |-> $past(boot_r) == PMI_BOOT)
        else $error("run started without boot in map zero");
    chk_clock_off: assert property (
        clock_output_disable_r |=> !instruction_clock_output)
        else $error("clock output active while disabled");
endmodule

// *** sim/pmi_ext_mem.sv ***
// External program memory model sitting on the shared bus
`timescale 1ns/100ps
module pmi_ext_mem (
    input wire logic clk_in,
    input wire pmi_pkg::pmi_addr_t addr_in,
    input wire logic addr_oe_n_in,
    input wire pmi_pkg::pmi_word_t bus_in,
    input wire logic sel_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    output pmi_pkg::pmi_word_t drive_out,
    output pmi_pkg::pmi_addr_t wr_addr_out
);
    import pmi_pkg::*;
    pmi_word_t mem [0:255];
    pmi_word_t last_r = '0;
    logic rd_en;
    logic wr_en;
    // Accesses count only when qualified by the select line
    assign rd_en = !sel_n_in && !rd_n_in && !addr_oe_n_in;
    assign wr_en = !sel_n_in && !wr_n_in && !addr_oe_n_in;
    // Idle bus shows a changing pattern, never the last value
    assign drive_out = rd_en ? mem[addr_in[7:0]] : ~last_r;
    always @(posedge clk_in) begin
        last_r <= drive_out;
        if (wr_en) begin
            mem[addr_in[7:0]] <= bus_in;
            wr_addr_out <= addr_in;
        end
    end
endmodule

// *** sim/program_memory_interface_reset_tb.sv ***
// Self-checking bench for the program memory interface
`timescale 1ns/100ps
`include "pmi_map.svh"
module program_memory_interface_reset_tb;
    import pmi_pkg::*;
    logic clk_in = 0, rst_in = 1;
    logic [4:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0, rdata, rv;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rr;
    logic map_sel = 0, breq = 0, bdone = 0, req = 0, we = 0, dacc = 0;
    logic bst, run, srst, imask, ien, ckout, ack, prev, bus_bad = 0;
    logic aoe_n, doe_n, sel_n, rd_n, wr_n;
    pmi_addr_t pa = '0, spc, aout, waddr;
    pmi_data_t pwd = '0;
    pmi_word_t prd, dout, mdrv, bus, w;
    int fail_count = 0, n_checks = 0, cyc = 0, sel_cnt = 0, lat, lint, t;

    always #4 clk_in = ~clk_in;
    assign bus = !doe_n ? dout : mdrv;

    pmi_top dut (.clk_in(clk_in), .rst_in(rst_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .memory_map_select_in(map_sel),
        .bus_request_in(breq), .boot_done_in(bdone),
        .boot_start_out(bst), .run_start_out(run), .start_pc_out(spc),
        .stack_reset_out(srst), .irq_mask_all_out(imask),
        .ints_enabled_out(ien), .instruction_clock_output(ckout),
        .pm_req_in(req), .pm_we_in(we), .pm_data_in(dacc),
        .pm_addr_in(pa), .pm_wdata_in(pwd), .pm_ack_out(ack),
        .pm_rdata_out(prd), .program_address_bus_out(aout),
        .program_address_bus_oe_n_out(aoe_n),
        .program_data_bus_out(dout), .program_data_bus_oe_n_out(doe_n),
        .program_data_bus_in(bus), .program_memory_select_n_out(sel_n),
        .rd_n_out(rd_n), .wr_n_out(wr_n));

    pmi_ext_mem mem_mdl (.clk_in(clk_in), .addr_in(aout),
        .addr_oe_n_in(aoe_n), .bus_in(bus), .sel_n_in(sel_n),
        .rd_n_in(rd_n), .wr_n_in(wr_n), .drive_out(mdrv),
        .wr_addr_out(waddr));

    // ****************************************
    // Checking, bus watch and timeout
    // ****************************************
    task end_sim();
        if (fail_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    always @(posedge clk_in) begin
        cyc++;
        if (!sel_n)
            sel_cnt++;
        if (sel_n && (!rd_n || !wr_n || !aoe_n || !doe_n))
            bus_bad <= 1;
        if (!doe_n && wr_n)
            bus_bad <= 1;
        if (cyc == 5000) begin
            fail_count++;
            end_sim();
        end
    end

    // ****************************************
    // Access tasks
    // ****************************************
    task axi_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_in);
        awaddr <= a; awvalid <= 1; wdata <= d; wstrb <= 4'hf;
        wvalid <= 1; bready <= 1;
        do begin
            @(posedge clk_in);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        bready <= 0;
        rr = bresp;
    endtask

    task axi_rd(input logic [4:0] a);
        @(posedge clk_in);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge clk_in);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        rready <= 0;
        rv = rdata;
        rr = rresp;
    endtask

    task pm_op(input logic w_e, d_a, input pmi_addr_t a,
               input pmi_data_t wd);
        @(posedge clk_in);
        req <= 1; we <= w_e; dacc <= d_a; pa <= a; pwd <= wd;
        sel_cnt = 0;
        lat = 0;
        do begin
            @(posedge clk_in);
            lat++;
        end while (ack !== 1'b1);
        req <= 0;
        w = prd;
    endtask

    task do_reset(input logic m, b);
        @(posedge clk_in);
        rst_in <= 1; map_sel <= m; breq <= b;
        repeat (8) @(posedge clk_in);
        #1;
        chk("stack_rst", srst, 1);
        chk("mask_rst", imask, 1);
        chk("ints_rst", ien, 1);
        chk("sel_rst", sel_n, 1);
        @(posedge clk_in);
        rst_in <= 0;
        @(posedge clk_in);
        #1;
        chk("stack_rel", srst, 0);
        chk("run_rel", run, m);
        chk("boot_rel", bst, !m && !b);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        do_reset(0, 1);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_in);
            #1;
            chk("boot_held", bst, 0);
        end
        breq <= 0;
        for (int i = 0; i < 5 && bst !== 1'b1; i++) @(posedge clk_in) #1;
        chk("boot_go", bst, 1);
        chk("no_run_boot", run, 0);
        axi_rd(`PMI_OFF_CTRL);
        chk("ctrl_rst", rv, 32'h0000_8007);
        axi_rd(`PMI_OFF_MODE);
        chk("mode_rst", rv, 32'h0000_0000);
        axi_rd(`PMI_OFF_STAT);
        chk("status_boot", rv, 32'h0000_000a);
        axi_wr(5'h10, 32'h0000_0001);
        chk("bresp_unm", rr, 2'h3);
        axi_rd(5'h14);
        chk("rresp_unm", rr, 2'h3);
        @(posedge clk_in) bdone <= 1;
        @(posedge clk_in) bdone <= 0;
        #1;
        for (int i = 0; i < 10 && run !== 1'b1; i++) @(posedge clk_in) #1;
        chk("run_go", run, 1);
        chk("start_pc", spc, 14'h0000);
        @(posedge clk_in) #1;
        chk("mask_off", imask, 0);
        t = 0;
        for (int i = 0; i < 4; i++) begin
            prev = ckout;
            @(posedge clk_in) #1;
            if (ckout !== prev) t++;
        end
        chk("ck_toggle", t, 4);
        axi_wr(`PMI_OFF_CTRL, 32'h0000_8000);
        axi_wr(`PMI_OFF_EXTB, 32'h0000_005a);
        pm_op(1, 1, 14'h0010, 16'habcd);
        lint = lat;
        chk("int_sel", sel_cnt, 0);
        pm_op(0, 1, 14'h0010, 16'h0000);
        chk("int_rd", w, 24'habcd5a);
        pm_op(1, 1, 14'h0800, 16'h1234);
        chk("ext_sel0", sel_cnt, 1);
        chk("ext_addr", waddr, 14'h0800);
        chk("lat_ws0", lat - lint, 0);
        axi_wr(`PMI_OFF_EXTB, 32'h0000_0000);
        pm_op(0, 1, 14'h0800, 16'h0000);
        chk("ext_rd", w, 24'h12345a);
        axi_rd(`PMI_OFF_EXTB);
        chk("xb_load", rv, 32'h0000_005a);
        axi_wr(`PMI_OFF_EXTB, 32'h0000_0011);
        pm_op(0, 0, 14'h0800, 16'h0000);
        axi_rd(`PMI_OFF_EXTB);
        chk("xb_insn", rv, 32'h0000_0011);
        axi_wr(`PMI_OFF_CTRL, 32'h0000_8007);
        pm_op(0, 1, 14'h2800, 16'h0000);
        chk("ext_sel7", sel_cnt, 8);
        chk("lat_ws7", lat - lint, 7);
        chk("ext_rd7", w, 24'h12345a);
        axi_wr(`PMI_OFF_CTRL, 32'h0000_4007);
        repeat (2) @(posedge clk_in);
        #1;
        chk("ints_off", ien, 0);
        t = 0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in) #1;
            if (ckout !== 1'b0) t++;
        end
        chk("ck_off", t, 0);
        do_reset(1, 0);
        pm_op(1, 1, 14'h3800, 16'h0f0f);
        chk("m1_int_sel", sel_cnt, 0);
        pm_op(0, 1, 14'h3800, 16'h0000);
        chk("m1_int_rd", w, 24'h0f0f00);
        pm_op(1, 1, 14'h0005, 16'h7777);
        chk("m1_ext_sel", sel_cnt, 8);
        chk("m1_ext_addr", waddr, 14'h0005);
        chk("bus_idle", bus_bad, 0);
        end_sim();
    end
endmodule
